//--- rtl/extirq_cfg.svh
`ifndef EXTIRQ_CFG_SVH
`define EXTIRQ_CFG_SVH

// register byte offsets
`define OFS_CFG_ONE 8'h00
`define OFS_CFG_TWO 8'h04
`define OFS_CFG_NMI 8'h08
`define OFS_SEL_BASE 8'h0C
`define OFS_UPPER_EN 8'h2C
`define OFS_STATUS 8'h30
`define OFS_MASK 8'h34
`define OFS_TSTAMP 8'h38
`define OFS_TCAPTURE 8'h3C

// line config fields
`define CFG_EN_BIT 0
`define CFG_SEL_BIT 1
`define CFG_POL_LSB 2
`define CFG_POL_MSB 3
`define CFG_RESET 4'h0

// polarity codes, bit0 rising, bit1 falling
`define POL_RISING 2'h1
`define POL_FALLING 2'h2
`define POL_BOTH 2'h3

`define SEL_RESET 5'h00
`define UPPER_EN_RESET 5'h00
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00

// detector slots
`define NUM_DET 8
`define DET_NMI 2
`define FIRST_PORT_B 3

`define TS_WIDTH_DEF 16

`endif

//--- rtl/extirq_pkg.sv
package extirq_pkg;
    typedef logic [1:0] edge_sel_t;
    typedef logic [4:0] pin_index_t;
    typedef logic [3:0] line_cfg_t;
endpackage

//--- rtl/edge_pulse_unit.sv
`timescale 1ns/1ns
module edge_pulse_unit (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic enable_i,
    input wire extirq_pkg::edge_sel_t pol_i,
    output logic pulse_o
);
    logic prev;
    logic primed;
    logic next_pulse;

    // no edge is judged until one sample has been taken after reset
    always_comb begin
        next_pulse = primed & enable_i &
            ((pol_i[0] & level_i & ~prev) | (pol_i[1] & ~level_i & prev));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
            primed <= 1'b0;
            pulse_o <= 1'b0;
        end else begin
            prev <= level_i;
            primed <= 1'b1;
            pulse_o <= next_pulse;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    rise_seen_a: assert property (
        primed && enable_i && pol_i[0] && $rose(level_i) |=> pulse_o)
        else $error("rising edge not reported");
    fall_seen_a: assert property (
        primed && enable_i && pol_i[1] && $fell(level_i) |=> pulse_o)
        else $error("falling edge not reported");
    no_edge_a: assert property (
        $stable(level_i) |=> !pulse_o)
        else $error("pulse without an edge");
    single_pulse_a: assert property (
        pulse_o |=> !pulse_o)
        else $error("pulse longer than one cycle");
endmodule // edge_pulse_unit

//--- rtl/ext_irq_front.sv
`timescale 1ns/1ns
`include "extirq_cfg.svh"
module ext_irq_front #(
    parameter int TS_WIDTH = `TS_WIDTH_DEF
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic [31:0] GPIO_PORT_A_I,
    input wire logic [31:0] GPIO_PORT_B_I,
    input wire logic ADC_SEQ_FIRST_I,
    input wire logic ADC_SEQ_SECOND_I,
    input wire logic FPU_OVF_LATCHED_I,
    input wire logic FPU_UNF_LATCHED_I,
    output logic [6:0] EXT_IRQ_O,
    output logic NMI_O,
    output logic CPU_IRQ_THIRTEEN_O,
    output logic GROUP1_SLOT1_O,
    output logic GROUP1_SLOT2_O,
    output logic ADC_COMBINED_IRQ_O,
    output logic FPU_OVF_IRQ_O,
    output logic FPU_UNF_IRQ_O,
    output logic IRQ_O
);
    if (TS_WIDTH < 8 || TS_WIDTH > 32) begin : g_bad_width
        $error("TS_WIDTH must lie between 8 and 32");
    end

    // register file
    extirq_pkg::line_cfg_t cfg [3];
    extirq_pkg::line_cfg_t next_cfg [3];
    extirq_pkg::pin_index_t pin_sel [`NUM_DET];
    extirq_pkg::pin_index_t next_pin_sel [`NUM_DET];
    logic [4:0] upper_en;
    logic [4:0] next_upper_en;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic [TS_WIDTH-1:0] tstamp;
    logic [TS_WIDTH-1:0] next_tstamp;
    logic [TS_WIDTH-1:0] tcapture;
    logic [TS_WIDTH-1:0] next_tcapture;

    // bus state
    logic next_wait;
    logic [31:0] next_rdata;
    logic write_take;

    // pin synchronisers
    logic [31:0] sync1_a;
    logic [31:0] sync2_a;
    logic [31:0] sync1_b;
    logic [31:0] sync2_b;

    logic [`NUM_DET-1:0] sel_level;
    logic [`NUM_DET-1:0] det_en;
    extirq_pkg::edge_sel_t det_pol [`NUM_DET];
    logic [`NUM_DET-1:0] det_pulse;
    logic route_mode;

    // next output values
    logic [6:0] next_ext;
    logic next_nmi;
    logic next_irq13;
    logic next_slot1;
    logic next_slot2;
    logic next_adc_comb;
    logic next_fpu_ovf;
    logic next_fpu_unf;
    logic next_irq;

    assign route_mode = cfg[`DET_NMI][`CFG_EN_BIT] & cfg[`DET_NMI][`CFG_SEL_BIT];

    // two flops on every pin before anything looks at it
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sync1_a <= 32'h0000_0000;
            sync2_a <= 32'h0000_0000;
            sync1_b <= 32'h0000_0000;
            sync2_b <= 32'h0000_0000;
        end else begin
            sync1_a <= GPIO_PORT_A_I;
            sync2_a <= sync1_a;
            sync1_b <= GPIO_PORT_B_I;
            sync2_b <= sync1_b;
        end
    end

    for (genvar k = 0; k < `NUM_DET; k++) begin : g_det
        if (k < `FIRST_PORT_B) begin : g_port_a
            assign sel_level[k] = sync2_a[pin_sel[k]];
            assign det_en[k] = cfg[k][`CFG_EN_BIT];
            assign det_pol[k] = cfg[k][`CFG_POL_MSB:`CFG_POL_LSB];
        end else begin : g_port_b
            assign sel_level[k] = sync2_b[pin_sel[k]];
            assign det_en[k] = upper_en[k-`FIRST_PORT_B];
            assign det_pol[k] = `POL_RISING;
        end
        edge_pulse_unit u_edge (
            .clk_i(SYS_CLK_I),
            .rst_n_i(NRST_I),
            .level_i(sel_level[k]),
            .enable_i(det_en[k]),
            .pol_i(det_pol[k]),
            .pulse_o(det_pulse[k])
        );
    end

    always_comb begin
        next_cfg = cfg;
        next_pin_sel = pin_sel;
        next_upper_en = upper_en;
        next_mask = mask;
        next_tcapture = tcapture;
        next_rdata = AVS_READDATA_O;
        // one wait cycle per access, then a single answer cycle
        next_wait = !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
        write_take = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
        if (write_take) begin
            unique case (AVS_ADDRESS_I)
                `OFS_CFG_ONE: next_cfg[0] = AVS_WRITEDATA_I[3:0];
                `OFS_CFG_TWO: next_cfg[1] = AVS_WRITEDATA_I[3:0];
                `OFS_CFG_NMI: next_cfg[2] = AVS_WRITEDATA_I[3:0];
                `OFS_UPPER_EN: next_upper_en = AVS_WRITEDATA_I[4:0];
                `OFS_MASK: next_mask = AVS_WRITEDATA_I[7:0];
                default: begin
                    for (int i = 0; i < `NUM_DET; i++) begin
                        if (AVS_ADDRESS_I == `OFS_SEL_BASE + 8'(4 * i)) begin
                            next_pin_sel[i] = AVS_WRITEDATA_I[4:0];
                        end
                    end
                end
            endcase
        end
        if (AVS_READ_I && AVS_WAITREQUEST_O) begin
            next_rdata = 32'h0000_0000;
            unique case (AVS_ADDRESS_I)
                `OFS_CFG_ONE: next_rdata[3:0] = cfg[0];
                `OFS_CFG_TWO: next_rdata[3:0] = cfg[1];
                `OFS_CFG_NMI: next_rdata[3:0] = cfg[2];
                `OFS_UPPER_EN: next_rdata[4:0] = upper_en;
                `OFS_STATUS: next_rdata[7:0] = status;
                `OFS_MASK: next_rdata[7:0] = mask;
                `OFS_TSTAMP: next_rdata[TS_WIDTH-1:0] = tstamp;
                `OFS_TCAPTURE: next_rdata[TS_WIDTH-1:0] = tcapture;
                default: begin
                    for (int i = 0; i < `NUM_DET; i++) begin
                        if (AVS_ADDRESS_I == `OFS_SEL_BASE + 8'(4 * i)) begin
                            next_rdata[4:0] = pin_sel[i];
                        end
                    end
                end
            endcase
        end
        // write one to clear; a new event in the same cycle wins
        next_status = status | det_pulse;
        if (write_take && AVS_ADDRESS_I == `OFS_STATUS) begin
            next_status = (status & ~AVS_WRITEDATA_I[7:0]) | det_pulse;
        end
        // stamp runs only in routed mode; each routed edge captures and restarts it
        if (!route_mode) begin
            next_tstamp = '0;
        end else if (det_pulse[`DET_NMI]) begin
            next_tcapture = tstamp;
            next_tstamp = '0;
        end else begin
            next_tstamp = tstamp + 1'b1;
        end
        next_ext = {det_pulse[7:3], det_pulse[1:0]};
        next_nmi = det_pulse[`DET_NMI] & ~route_mode;
        next_irq13 = det_pulse[`DET_NMI] & route_mode;
        next_slot1 = ADC_SEQ_FIRST_I;
        next_slot2 = ADC_SEQ_SECOND_I;
        next_adc_comb = ADC_SEQ_FIRST_I | ADC_SEQ_SECOND_I;
        next_fpu_ovf = FPU_OVF_LATCHED_I;
        next_fpu_unf = FPU_UNF_LATCHED_I;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < 3; i++) begin
                cfg[i] <= `CFG_RESET;
            end
            for (int i = 0; i < `NUM_DET; i++) begin
                pin_sel[i] <= `SEL_RESET;
            end
            upper_en <= `UPPER_EN_RESET;
            status <= `STATUS_RESET;
            mask <= `MASK_RESET;
            tstamp <= '0;
            tcapture <= '0;
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O <= 32'h0000_0000;
            EXT_IRQ_O <= 7'h00;
            NMI_O <= 1'b0;
            CPU_IRQ_THIRTEEN_O <= 1'b0;
            GROUP1_SLOT1_O <= 1'b0;
            GROUP1_SLOT2_O <= 1'b0;
            ADC_COMBINED_IRQ_O <= 1'b0;
            FPU_OVF_IRQ_O <= 1'b0;
            FPU_UNF_IRQ_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            cfg <= next_cfg;
            pin_sel <= next_pin_sel;
            upper_en <= next_upper_en;
            status <= next_status;
            mask <= next_mask;
            tstamp <= next_tstamp;
            tcapture <= next_tcapture;
            AVS_WAITREQUEST_O <= next_wait;
            AVS_READDATA_O <= next_rdata;
            EXT_IRQ_O <= next_ext;
            NMI_O <= next_nmi;
            CPU_IRQ_THIRTEEN_O <= next_irq13;
            GROUP1_SLOT1_O <= next_slot1;
            GROUP1_SLOT2_O <= next_slot2;
            ADC_COMBINED_IRQ_O <= next_adc_comb;
            FPU_OVF_IRQ_O <= next_fpu_ovf;
            FPU_UNF_IRQ_O <= next_fpu_unf;
            IRQ_O <= next_irq;
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    nmi_suppressed_a: assert property (
        route_mode |=> !NMI_O)
        else $error("nmi raised while routed to irq 13");
    irq13_routed_a: assert property (
        route_mode && det_pulse[`DET_NMI] |=> CPU_IRQ_THIRTEEN_O)
        else $error("routed edge missing on irq 13");
    stamp_runs_a: assert property (
        route_mode && !det_pulse[`DET_NMI] |=>
            tstamp == TS_WIDTH'($past(tstamp) + 1'b1))
        else $error("time stamp not counting");
    stamp_idle_a: assert property (
        !route_mode |=> tstamp == '0)
        else $error("time stamp runs outside routed mode");
    upper_line_a: assert property (
        det_pulse[`NUM_DET-1] |=> EXT_IRQ_O[6] ##1 !EXT_IRQ_O[6])
        else $error("line seven pulse wrong");
    adc_slots_a: assert property (
        ADC_SEQ_FIRST_I && !ADC_SEQ_SECOND_I |=>
            GROUP1_SLOT1_O && !GROUP1_SLOT2_O && ADC_COMBINED_IRQ_O)
        else $error("sequencer one routing wrong");
    fpu_flags_a: assert property (
        FPU_OVF_LATCHED_I && FPU_UNF_LATCHED_I |=> FPU_OVF_IRQ_O && FPU_UNF_IRQ_O)
        else $error("fpu flags not forwarded");
    pin_to_pulse_a: assert property (
        det_en[0] && det_pol[0] == `POL_RISING && $rose(sel_level[0])
            && $stable(pin_sel[0]) |=> ##1 EXT_IRQ_O[0])
        else $error("line one edge lost");
    status_sticky_a: assert property (
        status[0] && !(write_take && AVS_ADDRESS_I == `OFS_STATUS) |=> status[0])
        else $error("status bit lost without clear");
    irq_level_a: assert property (
        IRQ_O == |(status & mask))
        else $error("interrupt output disagrees with status");
    bus_answer_a: assert property (
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("no answer after one wait cycle");

    nmi_plain_a: assert property (
        !route_mode && det_pulse[`DET_NMI] |=> NMI_O && !CPU_IRQ_THIRTEEN_O)
        else $error("plain edge missing on nmi");

    routed_mode_c: cover property (route_mode && det_pulse[`DET_NMI]);
    both_edges_c: cover property (det_pol[0] == `POL_BOTH && EXT_IRQ_O[0]);
    line_seven_c: cover property (EXT_IRQ_O[6]);
    irq_rise_c: cover property ($rose(IRQ_O));
endmodule // ext_irq_front

//--- tb/gpio_pin_model.sv
`timescale 1ns/1ns
module gpio_pin_model (
    input wire logic clk_i,
    output logic [31:0] port_a_o,
    output logic [31:0] port_b_o
);
    // pins rest low; a change lands just after an edge and is held for many
    // cycles, since pulses shorter than a clock may be missed by the block
    initial begin
        port_a_o = 32'h0000_0000;
        port_b_o = 32'h0000_0000;
    end
    task automatic drive(input logic on_b, input int idx, input logic val);
        @(posedge clk_i);
        if (on_b) begin
            port_b_o[idx] <= val;
        end else begin
            port_a_o[idx] <= val;
        end
    endtask
endmodule // gpio_pin_model

//--- tb/test_external_interrupt_select_polarity.sv
`timescale 1ns/1ns
`include "extirq_cfg.svh"
module test_external_interrupt_select_polarity;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] avs_rdata;
    logic wait_req;
    logic [3:0] adcfpu = 4'h0;
    logic [31:0] pa;
    logic [31:0] pb;
    logic [6:0] ext;
    logic nmi, t13, s1, s2, comb, ovf, unf, irq;
    int cnt [9] = '{default: 0};
    int base [9] = '{default: 0};
    int num_errors = 0;
    int checked = 0;
    int pinsel [5] = '{0, 31, 7, 16, 9};

    initial begin
        forever #20 clk = ~clk;
    end

    gpio_pin_model pins (.clk_i(clk), .port_a_o(pa), .port_b_o(pb));

    ext_irq_front uut (
        .SYS_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(wait_req),
        .GPIO_PORT_A_I(pa), .GPIO_PORT_B_I(pb), .ADC_SEQ_FIRST_I(adcfpu[3]),
        .ADC_SEQ_SECOND_I(adcfpu[2]), .FPU_OVF_LATCHED_I(adcfpu[1]),
        .FPU_UNF_LATCHED_I(adcfpu[0]), .EXT_IRQ_O(ext), .NMI_O(nmi),
        .CPU_IRQ_THIRTEEN_O(t13), .GROUP1_SLOT1_O(s1), .GROUP1_SLOT2_O(s2),
        .ADC_COMBINED_IRQ_O(comb), .FPU_OVF_IRQ_O(ovf), .FPU_UNF_IRQ_O(unf), .IRQ_O(irq)
    );

    // high cycles per output; a stretched pulse shows up as an extra count
    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) begin
            cnt[i] += (ext[i] === 1'b1);
        end
        cnt[7] += (nmi === 1'b1);
        cnt[8] += (t13 === 1'b1);
    end

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wait_req !== 1'b0) begin
            n++;
            if (n > 50) begin
                chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
                tally_and_finish;
            end
            @(posedge clk);
        end
        rdata = avs_rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rdata);
    endtask

    task automatic pin(input logic on_b, input int idx, input logic val);
        pins.drive(on_b, idx, val);
        repeat (8) @(posedge clk);
    endtask

    task automatic pulses(input int idx, input int n, input string what);
        chk(what, n, cnt[idx] - base[idx]);
        base[idx] = cnt[idx];
    endtask

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`OFS_STATUS, 32'h0000_0000, "status after reset");
        rd_chk(`OFS_CFG_NMI, 32'h0000_0000, "nmi config after reset");
        rd_chk(8'h40, 32'h0000_0000, "unmapped read");
        bus(1'b1, `OFS_MASK, 32'h0000_00FF);
        for (int ln = 0; ln < 2; ln++) begin
            bus(1'b1, `OFS_SEL_BASE + 8'(4 * ln), 32'(3 + ln));
            for (int pol = 1; pol < 4; pol++) begin
                bus(1'b1, 8'(4 * ln), 32'({pol[1:0], 2'b01}));
                pin(1'b0, 3 + ln, 1'b1);
                pulses(ln, pol[0], "rise pulses");
                pin(1'b0, 3 + ln, 1'b0);
                pulses(ln, pol[1], "fall pulses");
            end
            bus(1'b1, 8'(4 * ln), 32'h0000_000C);
            pin(1'b0, 3 + ln, 1'b1);
            pin(1'b0, 3 + ln, 1'b0);
            pulses(ln, 0, "disabled line pulses");
        end
        rd_chk(`OFS_STATUS, 32'h0000_0003, "status lines one two");
        chk("irq level", 32'h0000_0001, {31'h0, irq});
        bus(1'b1, `OFS_STATUS, 32'h0000_0001);
        rd_chk(`OFS_STATUS, 32'h0000_0002, "status after clear one");
        bus(1'b1, `OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        bus(1'b1, `OFS_STATUS, 32'h0000_0002);
        bus(1'b1, `OFS_MASK, 32'h0000_00FF);
        // nonmaskable line on pin 5, plain mode then routed mode
        bus(1'b1, `OFS_SEL_BASE + 8'h08, 32'h0000_0005);
        bus(1'b1, `OFS_CFG_NMI, 32'h0000_0005);
        pin(1'b0, 5, 1'b1);
        pulses(7, 1, "nmi pulses");
        pulses(8, 0, "cpu irq 13 plain");
        pin(1'b0, 5, 1'b0);
        bus(1'b1, `OFS_CFG_NMI, 32'h0000_0007);
        repeat (10) @(posedge clk);
        bus(1'b0, `OFS_TSTAMP, 32'h0000_0000);
        chk("stamp running", 32'h0000_0001, {31'h0, rdata != 32'h0});
        pin(1'b0, 5, 1'b1);
        pulses(8, 1, "cpu irq 13 routed");
        pulses(7, 0, "nmi suppressed");
        bus(1'b0, `OFS_TCAPTURE, 32'h0000_0000);
        chk("stamp captured", 32'h0000_0001, {31'h0, rdata != 32'h0});
        bus(1'b1, `OFS_CFG_NMI, 32'h0000_0000);
        rd_chk(`OFS_TSTAMP, 32'h0000_0000, "stamp cleared");
        rd_chk(`OFS_STATUS, 32'h0000_0004, "status nmi");
        bus(1'b1, `OFS_STATUS, 32'h0000_00FF);
        pin(1'b0, 5, 1'b0);
        // upper lines from port B, boundary pins included
        // all selects first, so no enabled line still watches pin 0 when it rises
        for (int k = 3; k < 8; k++) begin
            bus(1'b1, `OFS_SEL_BASE + 8'(4 * k), 32'(pinsel[k - 3]));
        end
        bus(1'b1, `OFS_UPPER_EN, 32'h0000_001F);
        for (int k = 3; k < 8; k++) begin
            pin(1'b1, pinsel[k - 3], 1'b1);
            for (int j = 2; j < 7; j++) begin
                pulses(j, int'(j == k - 1), "upper line pulses");
            end
            pin(1'b1, pinsel[k - 3], 1'b0);
        end
        rd_chk(`OFS_STATUS, 32'h0000_00F8, "status upper lines");
        bus(1'b1, `OFS_UPPER_EN, 32'h0000_0000);
        pin(1'b1, 9, 1'b1);
        pulses(6, 0, "upper line disabled");
        for (int p = 0; p < 16; p++) begin
            @(posedge clk);
            adcfpu <= 4'(p);
            @(posedge clk);
            @(negedge clk);
            chk("adc slots", {29'h0, p[3] | p[2], p[2], p[3]}, {29'h0, comb, s2, s1});
            chk("fpu flags", {30'h0, p[1:0]}, {30'h0, ovf, unf});
        end
        tally_and_finish;
    end
endmodule // test_external_interrupt_select_polarity
